// >>> logic/supply_supervisor_watchdog.sv
// Behaviour
// - Reset active while supply below threshold
// - Release after configurable hold above threshold
// - Power-up asserts reset for hold period
// - Reset stays asserted as supply collapses
// - Watchdog expiry asserts reset when enabled
// - Start then stop restarts watchdog
// - Periods 200ms, 600ms, 1.4s or off
// - Period select kept in nonvolatile storage
// - Lock pin high refuses period change
// - Open-drain reset, polarity per variant
// - Data line monitored continuously, never gated
// - Select 00/01/10/11 = 1.4s/600ms/200ms/off
// - Start/stop are SDA edges while SCL high
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog #(
   parameter int unsigned HOLD_CNT  = supervisor_pkg::HOLD_CYCLES,
   parameter int unsigned WDT_SHORT = supervisor_pkg::WDT_SHORT_CYCLES,
   parameter int unsigned WDT_MID   = supervisor_pkg::WDT_MID_CYCLES,
   parameter int unsigned WDT_LONG  = supervisor_pkg::WDT_LONG_CYCLES,
   parameter bit          RST_HIGH  = 1'b0
) (
   // Clock and reset
   input  wire logic       mclk_in,
   input  wire logic       rst_n_in,
   // Supply comparator: high when supply is above the trip threshold
   input  wire logic       supply_ok_in,
   // Bus lines, sampled only
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   // Setting lock pin and period-select update request
   input  wire logic       lock_in,
   input  wire logic       sel_wr_in,
   input  wire logic [1:0] sel_val_in,
   // Open-drain reset pin
   output logic            sys_rst_out,
   output logic            sys_rst_oe_out,
   // Current period select
   output logic [1:0]      period_sel_out
);
   import supervisor_pkg::*;

   // Two-stage synchronisers for all pins
   bus_lines_s  sync1_q, sync2_q, prev_q;
   logic [2:0]  pin1_q, pin2_q;
   logic [1:0]  val1_q, val2_q;
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_q <= '{scl: 1'b1, sda: 1'b1};
         sync2_q <= '{scl: 1'b1, sda: 1'b1};
         prev_q  <= '{scl: 1'b1, sda: 1'b1};
         pin1_q  <= 3'h0;
         pin2_q  <= 3'h0;
         val1_q  <= 2'h0;
         val2_q  <= 2'h0;
      end else begin
         sync1_q <= '{scl: scl_in, sda: sda_in};
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
         pin1_q  <= {supply_ok_in, lock_in, sel_wr_in};
         pin2_q  <= pin1_q;
         val1_q  <= sel_val_in;
         val2_q  <= val1_q;
      end
   end

   wire logic supply_ok = pin2_q[2];
   wire logic lock      = pin2_q[1];
   wire logic sel_wr    = pin2_q[0];
   wire logic [1:0] sel_val = val2_q;

   // Data line watched at all times, no gating
   wire logic start_seen = prev_q.scl & sync2_q.scl & prev_q.sda & ~sync2_q.sda;
   wire logic stop_seen  = prev_q.scl & sync2_q.scl & ~prev_q.sda & sync2_q.sda;

   // Start arms, following stop restarts the count
   logic armed_q;
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in)       armed_q <= 1'b0;
      else if (start_seen) armed_q <= 1'b1;
      else if (stop_seen)  armed_q <= 1'b0;
   end
   wire logic kick = armed_q & stop_seen;

   // Period select retained; register models the nonvolatile cell
   // Factory setting only at first power; the reset pin must not clear it
   logic [1:0] sel_q = SEL_RESET;
   always_ff @(posedge mclk_in) begin
      if (sel_wr && !lock) sel_q <= sel_val;
   end
   // Value and strobe share one sync latency; still hold the value while strobe is up

   function automatic logic [CNT_W-1:0] limit_of(input logic [1:0] s);
      case (s)
         SEL_LONG:  limit_of = CNT_W'(WDT_LONG);
         SEL_MID:   limit_of = CNT_W'(WDT_MID);
         SEL_SHORT: limit_of = CNT_W'(WDT_SHORT);
         default:   limit_of = '0;
      endcase
   endfunction
   wire logic [CNT_W-1:0] wdt_limit = limit_of(sel_q);
   wire logic             wdt_on    = (sel_q != SEL_OFF);

   // Supervisor state machine
   sup_state_e         st_q, st_d;
   logic [CNT_W-1:0]   cnt_q, cnt_d;
   wire logic hold_done = (cnt_q >= CNT_W'(HOLD_CNT - 1));
   wire logic wdt_done  = wdt_on && (cnt_q >= wdt_limit - CNT_W'(1));

   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q + CNT_W'(1);
      case (st_q)
         // Hold count restarts while supply low
         ST_HOLD: begin
            if (!supply_ok) begin
               cnt_d = '0;
            end else if (hold_done) begin
               st_d  = ST_RUN;
               cnt_d = '0;
            end
         end
         // Expiry bites; host kicks keep it quiet
         ST_RUN: begin
            if (!supply_ok) begin
               st_d  = ST_HOLD;
               cnt_d = '0;
            end else if (kick || !wdt_on) begin
               cnt_d = '0;
            end else if (wdt_done) begin
               st_d  = ST_BITE;
               cnt_d = '0;
            end
         end
         // Bite holds reset for the power-up time
         ST_BITE: begin
            if (!supply_ok) begin
               st_d  = ST_HOLD;
               cnt_d = '0;
            end else if (hold_done) begin
               st_d  = ST_RUN;
               cnt_d = '0;
            end
         end
         default: begin
            st_d  = ST_HOLD;
            cnt_d = '0;
         end
      endcase
   end

   // Reset starts in hold state at power-up
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q  <= ST_HOLD;
         cnt_q <= '0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   // Asserted from reset and whenever the next state is not run; low supply forces hold
   wire logic rst_active_d = (st_d != ST_RUN);

   // Open drain: active-low variant pulls low, active-high releases to pull-up
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sys_rst_out    <= 1'b0;
         sys_rst_oe_out <= !RST_HIGH;
      end else begin
         sys_rst_out    <= 1'b0;
         sys_rst_oe_out <= RST_HIGH ? !rst_active_d : rst_active_d;
      end
   end

   // Select copy has no reset, so a power cycle shows the retained value
   always_ff @(posedge mclk_in) begin
      period_sel_out <= sel_q;
   end

   wire logic rst_asserted = RST_HIGH ? !sys_rst_oe_out : sys_rst_oe_out;

   // Assertions
   sequence s_low_supply;
      !supply_ok;
   endsequence

   AST_LOW_SUPPLY: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      s_low_supply |-> ##1 rst_asserted)
      else $error("reset not active with low supply");

   AST_HOLD_LEN: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (st_q == ST_HOLD && cnt_q == '0 && supply_ok) |-> ##1 (st_q == ST_HOLD))
      else $error("hold ended too early");

   AST_HOLD_RELEASE: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (st_q == ST_HOLD && supply_ok && hold_done) |-> ##1 (st_q == ST_RUN) ##1 !rst_asserted)
      else $error("reset not released after hold");

   AST_KICK: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (st_q == ST_RUN && supply_ok && kick) |-> ##1 (cnt_q == '0))
      else $error("kick did not restart count");

   AST_BITE: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (st_q == ST_RUN && supply_ok && !kick && wdt_done) |-> ##1 (st_q == ST_BITE) ##1 rst_asserted)
      else $error("watchdog expiry missed");

   AST_OFF: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (sel_q == SEL_OFF && st_q == ST_RUN && supply_ok) |-> ##1 (st_q == ST_RUN))
      else $error("disabled watchdog bit");

   AST_LOCK: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      lock |-> ##1 $stable(sel_q))
      else $error("select changed while locked");

   AST_SEL_MAP: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (sel_q == SEL_SHORT) |-> (wdt_limit == CNT_W'(WDT_SHORT)))
      else $error("select decode wrong");

   AST_BITE_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (st_q == ST_BITE && cnt_q == '0 && supply_ok) |-> ##1 (st_q == ST_BITE))
      else $error("bite hold too short");

   AST_OD: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      sys_rst_out == 1'b0 && rst_asserted == (st_q != ST_RUN))
      else $error("open drain pin wrong");
endmodule : supply_supervisor_watchdog
`default_nettype wire

// >>> logic/supervisor_pkg.sv
package supervisor_pkg;
   // Clock rate in kHz
   localparam int unsigned CLK_KHZ          = 50000;
   // Hold time after supply recovery or watchdog bite, in ms
   localparam int unsigned HOLD_MS          = 250;
   localparam int unsigned HOLD_CYCLES      = HOLD_MS * CLK_KHZ;
   // Watchdog periods in ms
   localparam int unsigned WDT_SHORT_MS     = 200;
   localparam int unsigned WDT_MID_MS       = 600;
   localparam int unsigned WDT_LONG_MS      = 1400;
   localparam int unsigned WDT_SHORT_CYCLES = WDT_SHORT_MS * CLK_KHZ;
   localparam int unsigned WDT_MID_CYCLES   = WDT_MID_MS * CLK_KHZ;
   localparam int unsigned WDT_LONG_CYCLES  = WDT_LONG_MS * CLK_KHZ;
   // Period select encodings
   localparam logic [1:0] SEL_LONG          = 2'h0;
   localparam logic [1:0] SEL_MID           = 2'h1;
   localparam logic [1:0] SEL_SHORT         = 2'h2;
   localparam logic [1:0] SEL_OFF           = 2'h3;
   localparam logic [1:0] SEL_RESET         = 2'h3;
   localparam int unsigned CNT_W            = 32;

   // Bus line pair after synchronisation
   typedef struct packed {
      logic scl;
      logic sda;
   } bus_lines_s;

   typedef enum logic [2:0] {
      ST_HOLD  = 3'h1,
      ST_RUN   = 3'h2,
      ST_BITE  = 3'h4
   } sup_state_e;
endpackage : supervisor_pkg

// >>> test/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
   // Clock
   input  wire logic mclk_in,
   // Bus lines, idle high by pull-up
   output var logic  scl_out,
   output var logic  sda_out
);
   // Released lines sit at the pull-up level
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // One line step is 4 clocks, so the link clock runs at 160 ns
   task automatic step(input logic c, input logic d);
      @(posedge mclk_in);
      scl_out <= c;
      sda_out <= d;
      repeat (3) @(posedge mclk_in);
   endtask : step
   // periodic restart; a lone stop when full is low
   task automatic restart(input bit full);
      step(full, !full);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask : restart
endmodule : host_bus_model
`default_nettype wire

// >>> test/supply_supervisor_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_tb;
   import supervisor_pkg::*;
   // Short counts keep the run brief
   localparam int unsigned HOLD = 50;
   localparam int unsigned WS   = 100;
   localparam int unsigned WM   = 200;
   localparam int unsigned WL   = 400;
   logic        mclk_in   = 1'b0;
   logic        rst_n_in  = 1'b0;
   logic        supply_ok = 1'b0;
   logic        lock      = 1'b0;
   logic        sel_wr    = 1'b0;
   logic [1:0]  sel_val   = 2'h0;
   logic [15:0] seed      = 16'h0003;
   logic [1:0]  sels [3]  = '{SEL_SHORT, SEL_MID, SEL_LONG};
   wire logic   scl, sda, rst_raw, rst_oe;
   wire logic [1:0] sel_seen;
   int          mismatches = 0;
   int          n_compared = 0;
   // Outputs captured mid-cycle, where they have settled
   logic        pin_s      = 1'b0;
   logic [1:0]  sel_s      = 2'h0;
   // Open-drain reset pin with pull-up, asserted low
   wire logic   rst_pin = rst_oe ? rst_raw : 1'b1;

   supply_supervisor_watchdog #(.HOLD_CNT(HOLD), .WDT_SHORT(WS), .WDT_MID(WM),
      .WDT_LONG(WL), .RST_HIGH(1'b0)) u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .supply_ok_in(supply_ok), .scl_in(scl), .sda_in(sda), .lock_in(lock),
      .sel_wr_in(sel_wr), .sel_val_in(sel_val), .sys_rst_out(rst_raw),
      .sys_rst_oe_out(rst_oe), .period_sel_out(sel_seen));
   host_bus_model u_host (.mclk_in(mclk_in), .scl_out(scl), .sda_out(sda));

   // Sample away from the launching edge to avoid a race
   always @(negedge mclk_in) begin
      pin_s <= rst_pin;
      sel_s <= sel_seen;
   end

   // 50 MHz clock
   initial begin
      forever #10 mclk_in = ~mclk_in;
   end
   function automatic int lim(input logic [1:0] s);
      return (s == SEL_SHORT) ? WS : (s == SEL_MID) ? WM : WL;
   endfunction : lim
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr
   task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic chk_pin(input string what, input logic exp);
      n_compared++;
      if (pin_s !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, pin_s);
      end
   endtask : chk_pin
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
   endtask : cyc
   // Bounded wait for a pin level
   task automatic wait_pin(input logic v, input int n);
      for (int i = 0; i < n && pin_s !== v; i++) @(posedge mclk_in);
   endtask : wait_pin
   // Pin must stay low for the hold, then release
   task automatic hold_chk(input string what);
      cyc(HOLD - 5);
      chk_pin(what, 1'b0);
      wait_pin(1'b1, 20);
      chk_pin(what, 1'b1);
   endtask : hold_chk
   task automatic set_sel(input logic [1:0] v);
      @(posedge mclk_in);
      sel_val <= v;
      sel_wr  <= 1'b1;
      cyc(4);
      sel_wr  <= 1'b0;
      cyc(6);
   endtask : set_sel
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   // Main sequence
   initial begin
      cyc(20);
      rst_n_in <= 1'b1;
      cyc(2);
      chk("sel_reset", SEL_RESET, sel_s);
      chk_pin("rst_pin_por", 1'b0);
      supply_ok <= 1'b1;
      hold_chk("powerup");
      supply_ok <= 1'b0;
      cyc(6);
      chk_pin("brownout", 1'b0);
      supply_ok <= 1'b1;
      hold_chk("recover");
      $display("test supply done");
      // Random enabled select, refused while the lock pin is high
      seed = lfsr(seed);
      lock <= 1'b1;
      set_sel(2'(seed % 3));
      chk("locked_sel", SEL_OFF, sel_s);
      cyc(WL + 50);
      chk_pin("wd_off", 1'b1);
      lock <= 1'b0;
      $display("test lock done");
      foreach (sels[k]) begin
         set_sel(sels[k]);
         chk("sel", sels[k], sel_s);
         for (int j = 0; j < 4; j++) begin
            seed = lfsr(seed);
            u_host.restart(1'b1);
            cyc(seed % (lim(sels[k]) / 2));
         end
         chk_pin("kicked", 1'b1);
         u_host.restart(1'b1);
         u_host.restart(1'b0);
         cyc(lim(sels[k]) - 30);
         chk_pin("early_bite", 1'b1);
         wait_pin(1'b0, 40);
         chk_pin("bite", 1'b0);
         hold_chk("bite_hold");
         $display("test period %0h done", sels[k]);
      end
      // Power cycle mid-run: pin asserted at once, select retained
      rst_n_in <= 1'b0;
      cyc(2);
      chk_pin("rerun_por", 1'b0);
      chk("sel_kept", SEL_LONG, sel_s);
      rst_n_in <= 1'b1;
      hold_chk("rerun_hold");
      $display("test power cycle done");
      close_out();
   end
   // Watchdog against a hang
   initial begin
      cyc(20000);
      mismatches++;
      close_out();
   end
endmodule : supply_supervisor_watchdog_tb
`default_nettype wire
